// >>> rtl/rstr_ctrl.sv
// Purpose: APB register interface and sequencing of a reset controller
// Assumes: One clock pclk at 25 MHz; slow clock is an enable from a divider
// Notes:   External reset pin is split into in, out and enable (enable low drives)
// Notes on behaviour
// RULE1: Keyed command bit 0 resets the processor
// RULE2: Keyed command bit 2 resets peripherals
// RULE3: Keyed command bit 3 drives pin low
// RULE4: Writes without key 0xa5 ignored entirely
// RULE5: Pin falling edge sets sticky flag
// RULE6: Status read clears flag and interrupt
// RULE7: Interrupt when flag, irq enable, pin reset off
// RULE8: Cause code in status bits 10 to 8
// RULE9: Status read leaves cause unchanged
// RULE10: Pin level sampled every clock into bit 16
// RULE11: Busy bit 17 during soft reset
// RULE12: Software waits for busy clear
// RULE13: Mode bit 0 enables pin-triggered reset
// RULE14: Pin pulse lasts 2^(length+1) slow cycles
// RULE15: Mode writes blocked when write-protected
// RULE16: Soft reset lasts three slow cycles
// RULE17: Command writes ignored while busy
// RULE18: Length zero gives two-cycle pulse
// RULE19: Soft cause only with processor bit
// RULE20: Reserved and key bits read zero
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "rstr_defines.svh"

module rstr_ctrl (
  input  wire logic                 pclk,            // APB clock
  input  wire logic                 presetn,         // Async reset, active low
  input  wire logic                 psel,            // APB select
  input  wire logic                 penable,         // APB access phase
  input  wire logic                 pwrite,          // APB write
  input  wire logic [11:0]          paddr,           // APB byte address
  input  wire logic [31:0]          pwdata,          // APB write data
  output logic      [31:0]          prdata,          // APB read data
  output logic                      pready,          // APB ready
  output logic                      pslverr,         // APB error
  input  wire logic                 write_protect_enable, // System write protection
  input  wire logic                 pin_in,          // External reset pin level
  output logic                      pin_out,         // External reset pin output value
  output logic                      pin_oe_n,        // Low while driving the pin
  output rstr_pkg::rstr_resets_t    resets,          // Internal reset requests, active high
  output logic                      irq              // Pin fall interrupt
);
  import rstr_pkg::*;

  // Mode reset value kept whole so each field is cut from it explicitly
  localparam logic [31:0] mode_reset_val = `RSTR_MODE_RESET;

  typedef enum logic [1:0] {
    RSTR_IDLE = 2'b00,
    RSTR_SOFT = 2'b01,
    RSTR_USER = 2'b11
  } rstr_state_t;

  logic              fall_flag_reg;
  logic              level_reg;
  logic [2:0]        cause_reg;
  logic              pin_reset_enable_reg;
  logic              irq_enable_reg;
  logic [3:0]        pulse_length_reg;
  rstr_state_t       state_reg;
  logic [1:0]        soft_cnt_reg;
  logic              cpu_pending_reg;
  logic [16:0]       pulse_cnt_reg;
  logic [9:0]        div_reg;
  logic              slow_tick;
  logic              wr_en;
  logic              rd_en;
  logic              key_ok;
  logic              cmd_hit;
  logic              status_read;
  logic              busy;
  logic              pin_low_seen;
  rstr_resets_t      resets_reg;

  assign wr_en       = psel && penable && pwrite;
  assign rd_en       = psel && penable && !pwrite;
  // Single-cycle access keeps the master's wait trivial
  assign pready      = 1'b1;
  assign pslverr     = 1'b0;
  // RULE4: key check
  assign key_ok      = pwdata[`RSTR_KEY_HI:`RSTR_KEY_LO] == `RSTR_KEY_VALUE;
  assign busy        = state_reg == RSTR_SOFT;
  assign status_read = rd_en && (paddr == `RSTR_OFS_STATUS);
  // RULE17: command blocked while busy
  assign cmd_hit     = wr_en && (paddr == `RSTR_OFS_CMD) && key_ok && !busy
                       && (state_reg == RSTR_IDLE)
                       && (pwdata[`RSTR_CMD_CPU] || pwdata[`RSTR_CMD_PERIPH] || pwdata[`RSTR_CMD_PIN]);
  // Pin driven low by us does not count as a user reset
  assign pin_low_seen = !level_reg && pin_oe_n;

  // Slow clock enable from the 25 MHz clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_reg <= 10'h000;
    else if (div_reg == `RSTR_SLOW_DIV - 10'd1)
      div_reg <= 10'h000;
    else
      div_reg <= div_reg + 10'd1;
  end
  assign slow_tick = div_reg == `RSTR_SLOW_DIV - 10'd1;

  // RULE10: pin level sampled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      level_reg <= 1'b1;
    else
      level_reg <= pin_in;
  end

  // RULE5: falling edge sets flag; RULE6: read clears, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fall_flag_reg <= 1'b0;
    else if (level_reg && !pin_in)
      fall_flag_reg <= 1'b1;
    else if (status_read)
      fall_flag_reg <= 1'b0;
  end

  // RULE7: interrupt gating
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= ((level_reg && !pin_in) || (fall_flag_reg && !status_read))
             && irq_enable_reg && !pin_reset_enable_reg;
  end

  // RULE15: mode write needs key and no protection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_reset_enable_reg <= mode_reset_val[`RSTR_MD_PIN_EN];
      irq_enable_reg       <= mode_reset_val[`RSTR_MD_IRQ_EN];
      pulse_length_reg     <= mode_reset_val[`RSTR_MD_LEN_HI:`RSTR_MD_LEN_LO];
    end
    else if (wr_en && (paddr == `RSTR_OFS_MODE) && key_ok && !write_protect_enable)
    begin
      pin_reset_enable_reg <= pwdata[`RSTR_MD_PIN_EN];
      irq_enable_reg       <= pwdata[`RSTR_MD_IRQ_EN];
      pulse_length_reg     <= pwdata[`RSTR_MD_LEN_HI:`RSTR_MD_LEN_LO];
    end
  end

  // RULE16: soft reset and RULE13: user reset sequencing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg       <= RSTR_IDLE;
      soft_cnt_reg    <= 2'h0;
      cpu_pending_reg <= 1'b0;
      resets_reg      <= '0;
    end
    else
    begin
      case (state_reg)
        RSTR_IDLE:
        begin
          if (cmd_hit)
          begin
            // RULE1: processor reset
            resets_reg.cpu    <= pwdata[`RSTR_CMD_CPU];
            // RULE2: peripheral reset
            resets_reg.periph <= pwdata[`RSTR_CMD_PERIPH];
            resets_reg.pin    <= 1'b0;
            cpu_pending_reg   <= pwdata[`RSTR_CMD_CPU];
            soft_cnt_reg      <= 2'h0;
            state_reg         <= RSTR_SOFT;
          end
          else if (pin_low_seen && pin_reset_enable_reg && slow_tick)
          begin
            resets_reg.cpu    <= 1'b1;
            resets_reg.periph <= 1'b1;
            state_reg         <= RSTR_USER;
          end
        end
        RSTR_SOFT:
        begin
          if (slow_tick)
          begin
            if (soft_cnt_reg == `RSTR_SOFT_CYCLES - 2'h1)
            begin
              resets_reg.cpu    <= 1'b0;
              resets_reg.periph <= 1'b0;
              state_reg         <= RSTR_IDLE;
            end
            else
              soft_cnt_reg <= soft_cnt_reg + 2'h1;
          end
        end
        RSTR_USER:
        begin
          // Held until the pin is seen high on a slow tick
          if (level_reg && slow_tick)
          begin
            resets_reg.cpu    <= 1'b0;
            resets_reg.periph <= 1'b0;
            state_reg         <= RSTR_IDLE;
          end
        end
        default:
          state_reg <= RSTR_IDLE;
      endcase
    end
  end
  assign resets = '{cpu: resets_reg.cpu, periph: resets_reg.periph, pin: !pin_oe_n};

  // RULE8: cause updated on processor reset release; RULE19: soft only with cpu bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cause_reg <= RSTR_CAUSE_GENERAL;
    else if (state_reg == RSTR_SOFT && slow_tick && soft_cnt_reg == `RSTR_SOFT_CYCLES - 2'h1
             && cpu_pending_reg)
      cause_reg <= RSTR_CAUSE_SOFT;
    else if (state_reg == RSTR_USER && level_reg && slow_tick)
      cause_reg <= RSTR_CAUSE_PIN;
  end

  // RULE3: pin drive; RULE14 and RULE18: length 2^(n+1) slow cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pulse_cnt_reg <= 17'h00000;
      pin_oe_n      <= 1'b1;
    end
    else if (cmd_hit && pwdata[`RSTR_CMD_PIN])
    begin
      pulse_cnt_reg <= 17'((18'h00002 << pulse_length_reg) - 18'h1);
      pin_oe_n      <= 1'b0;
    end
    else if (!pin_oe_n && slow_tick)
    begin
      if (pulse_cnt_reg == 17'h00000)
        pin_oe_n <= 1'b1;
      else
        pulse_cnt_reg <= pulse_cnt_reg - 17'h00001;
    end
  end
  assign pin_out = 1'b0;

  // RULE20: reserved and key bits read zero; RULE9: read leaves cause
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h00000000;
      if (paddr == `RSTR_OFS_STATUS)
      begin
        // A fall caught on the setup edge must reach this read, since its access clears the flag
        prdata[`RSTR_ST_FALL]                       <= fall_flag_reg || (level_reg && !pin_in);
        prdata[`RSTR_ST_CAUSE_HI:`RSTR_ST_CAUSE_LO] <= cause_reg;
        prdata[`RSTR_ST_LEVEL]                      <= level_reg;
        // RULE11: busy flag
        prdata[`RSTR_ST_BUSY]                       <= busy;
      end
      else if (paddr == `RSTR_OFS_MODE)
      begin
        prdata[`RSTR_MD_PIN_EN]                 <= pin_reset_enable_reg;
        prdata[`RSTR_MD_IRQ_EN]                 <= irq_enable_reg;
        prdata[`RSTR_MD_LEN_HI:`RSTR_MD_LEN_LO] <= pulse_length_reg;
      end
    end
  end

  property p_cmd_starts_busy;
    @(posedge pclk) disable iff (!presetn) cmd_hit |=> busy;
  endproperty
  a_cmd_starts_busy: assert property (p_cmd_starts_busy) else $error("busy not set"); // RULE11

  property p_cpu_cmd;
    @(posedge pclk) disable iff (!presetn) cmd_hit && pwdata[0] |=> resets.cpu;
  endproperty
  a_cpu_cmd: assert property (p_cpu_cmd) else $error("cpu reset missing"); // RULE1

  property p_periph_cmd;
    @(posedge pclk) disable iff (!presetn) cmd_hit && pwdata[2] |=> resets.periph;
  endproperty
  a_periph_cmd: assert property (p_periph_cmd) else $error("periph reset missing"); // RULE2

  property p_pin_cmd;
    @(posedge pclk) disable iff (!presetn) cmd_hit && pwdata[3] |=> !pin_oe_n && !pin_out;
  endproperty
  a_pin_cmd: assert property (p_pin_cmd) else $error("pin not driven"); // RULE3

  property p_bad_key;
    @(posedge pclk) disable iff (!presetn)
      wr_en && paddr == 12'h008 && pwdata[31:24] != 8'ha5 |=> $stable(pulse_length_reg) && $stable(irq_enable_reg);
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("unkeyed mode write took effect"); // RULE4

  property p_fall_sets;
    @(posedge pclk) disable iff (!presetn) level_reg && !pin_in |=> fall_flag_reg;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("fall flag not set"); // RULE5

  property p_read_clears;
    @(posedge pclk) disable iff (!presetn) status_read && !(level_reg && !pin_in) |=> !fall_flag_reg && !irq;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear flag"); // RULE6

  property p_irq_gate;
    @(posedge pclk) disable iff (!presetn) irq |-> $past(irq_enable_reg) && !$past(pin_reset_enable_reg);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable"); // RULE7

  property p_level;
    @(posedge pclk) disable iff (!presetn) ##1 level_reg == $past(pin_in);
  endproperty
  a_level: assert property (p_level) else $error("level not sampled"); // RULE10

  property p_cause_stable_read;
    @(posedge pclk) disable iff (!presetn) status_read && state_reg == RSTR_IDLE |=> $stable(cause_reg);
  endproperty
  a_cause_stable_read: assert property (p_cause_stable_read) else $error("read changed cause"); // RULE9

  c_soft: cover property (@(posedge pclk) disable iff (!presetn) cmd_hit ##1 busy);
  c_user: cover property (@(posedge pclk) disable iff (!presetn) state_reg == RSTR_USER);
  c_irq:  cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule : rstr_ctrl

// >>> rtl/rstr_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the reset controller
// Assumes: 32-bit APB data, byte addresses
// Notes:   Definitions only
`ifndef RSTR_DEFINES_SVH
`define RSTR_DEFINES_SVH
`define RSTR_OFS_CMD        12'h000
`define RSTR_OFS_STATUS     12'h004
`define RSTR_OFS_MODE       12'h008
`define RSTR_KEY_VALUE      8'ha5
`define RSTR_KEY_HI         31
`define RSTR_KEY_LO         24
`define RSTR_CMD_CPU        0
`define RSTR_CMD_PERIPH     2
`define RSTR_CMD_PIN        3
`define RSTR_ST_FALL        0
`define RSTR_ST_CAUSE_HI    10
`define RSTR_ST_CAUSE_LO    8
`define RSTR_ST_LEVEL       16
`define RSTR_ST_BUSY        17
`define RSTR_MD_PIN_EN      0
`define RSTR_MD_IRQ_EN      4
`define RSTR_MD_LEN_HI      11
`define RSTR_MD_LEN_LO      8
`define RSTR_MODE_RESET     32'h00000001
`define RSTR_SOFT_CYCLES    2'h3
`define RSTR_SLOW_DIV       10'd763
`endif

// >>> rtl/rstr_pkg.sv
// Purpose: Types shared by the reset controller
// Assumes: Used together with rstr_defines.svh
// Notes:   Cause codes as reported in the status register
package rstr_pkg;
  typedef enum logic [2:0] {
    RSTR_CAUSE_GENERAL  = 3'h0,
    RSTR_CAUSE_BACKUP   = 3'h1,
    RSTR_CAUSE_WATCHDOG = 3'h2,
    RSTR_CAUSE_SOFT     = 3'h3,
    RSTR_CAUSE_PIN      = 3'h4
  } rstr_cause_t;

  typedef struct packed {
    logic       cpu;
    logic       periph;
    logic       pin;
  } rstr_resets_t;
endpackage : rstr_pkg

// >>> tb/rstr_ext_dev.sv
// Purpose: External device sharing the open-drain reset line
// Assumes: The line has a pull-up and any party may pull it low
// Notes:   The bench commands the external pull through pull_low
`timescale 1ns/1ps

module rstr_ext_dev (
  input  wire logic pin_out,   // Controller output value
  input  wire logic pin_oe_n,  // Controller drives when low
  input  wire logic pull_low,  // External device pulls low
  output logic      pin_level  // Resolved line level
);
  // Wired-AND: a released line rises to the pull-up, never keeps a stale low
  assign pin_level = !(pull_low || (!pin_oe_n && !pin_out));
endmodule : rstr_ext_dev

// >>> tb/rstr_ctrl_bench.sv
// Purpose: Register-level checks of the reset controller
// Assumes: Zero-wait APB slave, one external device on the reset line
// Notes:   Slow tick length taken from the divider define
`timescale 1ns/1ps
`include "rstr_defines.svh"

module rstr_ctrl_bench;
  import rstr_pkg::*;
  localparam int          tick    = int'(`RSTR_SLOW_DIV);
  localparam logic [11:0] ofs_cmd = 12'h000;
  localparam logic [11:0] ofs_st  = 12'h004;
  localparam logic [11:0] ofs_md  = 12'h008;
  localparam logic [31:0] all_m   = 32'hffffffff;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         wp = 1'b0;
  logic         pull_low = 1'b0;
  logic         pin_in;
  logic         pin_out;
  logic         pin_oe_n;
  rstr_resets_t resets;
  logic         irq;
  logic [31:0]  rd;
  int           n;
  int           fail_count = 0;
  int           cmp_count = 0;

  always #20 pclk = ~pclk;

  rstr_ctrl rstr_ctrl_inst (
    .pclk                 (pclk),
    .presetn              (presetn),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .write_protect_enable (wp),
    .pin_in               (pin_in),
    .pin_out              (pin_out),
    .pin_oe_n             (pin_oe_n),
    .resets               (resets),
    .irq                  (irq)
  );

  rstr_ext_dev rstr_ext_dev_inst (
    .pin_out   (pin_out),
    .pin_oe_n  (pin_oe_n),
    .pull_low  (pull_low),
    .pin_level (pin_in)
  );

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    chk({31'h0, pslverr}, 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rchk

  // Cycles for which the chosen output stays at lv
  task automatic span(input int w, input logic lv);
    n = 0;
    while (n < 20000 && (w == 0 ? resets.periph : w == 1 ? resets.cpu : !pin_oe_n) === lv)
    begin
      // Falling edge keeps the look away from the edge that launches the outputs
      @(negedge pclk);
      n++;
    end
  endtask : span

  task automatic rng(input int lo, input int hi);
    chk((n >= lo && n <= hi) ? lo : n, lo);
  endtask : rng

  initial
  begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rchk(ofs_st, all_m, 32'h00010000);
    rchk(ofs_md, all_m, 32'h00000001);
    rchk(12'h00c, all_m, 32'h0);
    apb(1'b1, ofs_md, 32'h00000010);
    rchk(ofs_md, all_m, 32'h1);
    wp <= 1'b1;
    apb(1'b1, ofs_md, 32'ha5000010);
    rchk(ofs_md, all_m, 32'h1);
    wp <= 1'b0;
    apb(1'b1, ofs_md, 32'ha5000010);
    rchk(ofs_md, all_m, 32'h10);
    pull_low <= 1'b1;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk(irq, 32'h1);
    rchk(ofs_st, all_m, 32'h1);
    repeat (2) @(negedge pclk);
    chk(irq, 32'h0);
    @(posedge pclk);
    pull_low <= 1'b0;
    repeat (4) @(posedge pclk);
    rchk(ofs_st, all_m, 32'h00010000);
    apb(1'b1, ofs_cmd, 32'h5a000009);
    @(negedge pclk);
    chk({resets, pin_oe_n}, 32'h1);
    apb(1'b1, ofs_cmd, 32'ha5000004);
    @(negedge pclk);
    chk(resets, 32'h2);
    rchk(ofs_st, 32'h00020700, 32'h00020000);
    // Command during busy must be dropped
    apb(1'b1, ofs_cmd, 32'ha5000001);
    @(negedge pclk);
    chk(resets.cpu, 32'h0);
    // Span starts six cycles after the command edge
    span(0, 1'b1);
    rng(2 * tick - 8, 3 * tick);
    rchk(ofs_st, 32'h00020700, 32'h0);
    apb(1'b1, ofs_cmd, 32'ha5000009);
    @(negedge pclk);
    chk({resets, pin_oe_n}, 32'ha);
    span(2, 1'b1);
    rng(tick, 2 * tick);
    span(1, 1'b1);
    rchk(ofs_st, 32'h00020700, 32'h300);
    rchk(ofs_st, 32'h00000700, 32'h300);
    apb(1'b1, ofs_md, 32'ha5000110);
    rchk(ofs_md, all_m, 32'h110);
    apb(1'b1, ofs_cmd, 32'ha5000008);
    @(negedge pclk);
    span(2, 1'b1);
    rng(3 * tick, 4 * tick);
    rchk(ofs_st, 32'h00020700, 32'h300);
    apb(1'b1, ofs_md, 32'ha5000011);
    pull_low <= 1'b1;
    // Entry waits for the next slow tick after the pin is seen low
    span(1, 1'b0);
    rng(2, tick + 2);
    @(negedge pclk);
    chk({resets.periph, irq}, 32'h2);
    @(posedge pclk);
    pull_low <= 1'b0;
    span(1, 1'b1);
    rng(2, tick + 2);
    rchk(ofs_st, 32'h00000700, 32'h400);
    tally_and_finish();
  end
endmodule : rstr_ctrl_bench
